// File: ctac_defs.svh
// Register offsets, field positions, reset values and timing counts of the touch scanner
`ifndef CTAC_DEFS_SVH
`define CTAC_DEFS_SVH

`define CTAC_OFS_CTRL 8'h00
`define CTAC_OFS_THRESH 8'h04
`define CTAC_OFS_TIMING 8'h08
`define CTAC_OFS_STATUS 8'h0C
`define CTAC_OFS_MASK 8'h10
`define CTAC_OFS_RESULT 8'h14

`define CTAC_CTRL_MODE_LSB 0
`define CTAC_CTRL_LOWER_BIT 2
`define CTAC_CTRL_FDIV_LSB 8
`define CTAC_CTRL_XSEL_LSB 16

`define CTAC_ST_YES 0
`define CTAC_ST_NO 1
`define CTAC_ST_DONE 2
`define CTAC_ST_TIMEOUT_COUNT_LIMIT 3

`define CTAC_ROUND_TICKS 4096
`define CTAC_TIMEOUT_COUNT_LIMIT_RST 12'hFFF
`define CTAC_THRESH_RST 12'h000

`endif

// File: ctac_pkg.sv
// Types shared by the touch scanner
package ctac_pkg;
    typedef enum logic [2:0] {
        CTAC_IDLE = 3'b000,
        CTAC_GAP = 3'b001,
        CTAC_DRIVE = 3'b010,
        CTAC_SENSE = 3'b011,
        CTAC_JUDGE = 3'b100,
        CTAC_WAIT = 3'b101
    } ctac_state_t;

    typedef enum logic [1:0] {
        CTAC_MODE_OFF = 2'b00,
        CTAC_MODE_NOW = 2'b01,
        CTAC_MODE_CONT = 2'b10
    } ctac_mode_t;
endpackage : ctac_pkg

// File: ctac_scanner.sv
// Capacitive touch scanner with hardware threshold compare and Wishbone registers
// How it works
// - One shared count threshold is applied to every enabled channel.
// - Hardware compares each channel count at measurement end and raises touch events.
// - Each measurement raises exactly one of touch or no-touch.
// - On touch, the measured channel index is captured into the result register.
// - Event flags stay set until software clears them by reading status.
// - Scanning continues in low power; a touch raises a wake-up request when its mask bit is set.
// - Continuous mode repeats scan rounds without software; select it last.
// - Lower-is-touch bit clear: higher count is touch; set: directions swap.
// - A count reaching the timeout limit raises a timeout event.
// - Rounds are separated by round interval times 4096 function-clock periods.
// - Comparator crossing stops recharge and stores the count as sensing value.
//
// Our own choices: the Wishbone register port and the register addresses.
`timescale 1ns/1ps
`include "ctac_defs.svh"

module ctac_scanner #(
    parameter int NCH = 16,
    parameter int CW = 12
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // Touch pads
    output logic [NCH-1:0] x_drive_o,
    output logic [NCH-1:0] x_oe_o,
    input wire logic y_cross_i,
    // System
    output logic irq_o,
    output logic wake_o
);
    import ctac_pkg::*;
    localparam int CHW = $clog2(NCH);

    ctac_state_t state_ff;
    ctac_mode_t mode_ff;
    logic lower_ff;
    logic [3:0] fdiv_ff;
    logic [NCH-1:0] xsel_ff;
    logic xgnd_ff;
    logic [CW-1:0] thresh_ff;
    logic [CW-1:0] timeout_count_limit_ff;
    logic [7:0] round_ff;
    logic [7:0] rdelay_ff;
    logic [3:0] status_ff;
    logic [3:0] mask_ff;
    logic [CW-1:0] count_ff;
    logic [$clog2(NCH)-1:0] chan_ff;
    logic [$clog2(NCH)-1:0] touched_channel_index_ff;
    logic [CW-1:0] sense_ff;
    logic [3:0] div_ff;
    logic tick_ff;
    logic [19:0] wait_ff;
    logic [1:0] cross_sync_ff;
    logic now_ff;
    logic [3:0] ev;
    logic wr_en;
    logic rd_en;
    logic is_touch;
    logic timed_out;
    logic [$clog2(NCH)-1:0] nxt_chan;
    logic found;
    logic rd_clr;
    logic [3:0] nxt_status;

    assign wr_en = cyc_i & stb_i & we_i & ~ack_o;
    assign rd_en = cyc_i & stb_i & ~we_i & ~ack_o;

    // Two-flop sync of the asynchronous comparator level
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cross_sync_ff <= 2'h0;
        end else begin
            cross_sync_ff <= {cross_sync_ff[0], y_cross_i};
        end
    end

    // Function-clock tick; divider 0 gives every clock (undivided source)
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            div_ff <= 4'h0;
            tick_ff <= 1'b0;
        end else if (div_ff >= fdiv_ff) begin
            div_ff <= 4'h0;
            tick_ff <= 1'b1;
        end else begin
            div_ff <= div_ff + 4'h1;
            tick_ff <= 1'b0;
        end
    end

    // Register writes; mode written last by software starts the scan
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mode_ff <= CTAC_MODE_OFF;
            lower_ff <= 1'b0;
            fdiv_ff <= 4'h0;
            xsel_ff <= '0;
            xgnd_ff <= 1'b0;
            thresh_ff <= `CTAC_THRESH_RST;
            timeout_count_limit_ff <= `CTAC_TIMEOUT_COUNT_LIMIT_RST;
            round_ff <= 8'h00;
            rdelay_ff <= 8'h00;
            mask_ff <= 4'h0;
        end else if (wr_en && adr_i == `CTAC_OFS_CTRL && sel_i[0]) begin
            mode_ff <= ctac_mode_t'(dat_i[`CTAC_CTRL_MODE_LSB +: 2]);
            lower_ff <= dat_i[`CTAC_CTRL_LOWER_BIT];
            xgnd_ff <= dat_i[3];
            fdiv_ff <= dat_i[`CTAC_CTRL_FDIV_LSB +: 4];
            xsel_ff <= dat_i[`CTAC_CTRL_XSEL_LSB +: NCH];
        end else if (wr_en && adr_i == `CTAC_OFS_THRESH) begin
            thresh_ff <= dat_i[CW-1:0];
            timeout_count_limit_ff <= dat_i[16 +: CW];
        end else if (wr_en && adr_i == `CTAC_OFS_TIMING) begin
            round_ff <= dat_i[7:0];
            rdelay_ff <= dat_i[15:8];
        end else if (wr_en && adr_i == `CTAC_OFS_MASK) begin
            mask_ff <= dat_i[3:0];
        end
    end

    // Next enabled channel after the current one, wrapping
    always_comb begin
        nxt_chan = chan_ff;
        found = 1'b0;
        for (int i = 1; i <= NCH; i++) begin
            if (!found && xsel_ff[(int'(chan_ff) + i) % NCH]) begin
                nxt_chan = CHW'((int'(chan_ff) + i) % NCH);
                found = 1'b1;
            end
        end
    end

    // Shared threshold compare, direction set by lower-is-touch
    assign is_touch = lower_ff ? (count_ff < thresh_ff) : (count_ff > thresh_ff);
    assign timed_out = count_ff >= timeout_count_limit_ff;
    // Exactly one of yes/no on each judged channel
    assign ev[`CTAC_ST_YES] = state_ff == CTAC_JUDGE && is_touch;
    assign ev[`CTAC_ST_NO] = state_ff == CTAC_JUDGE && !is_touch;
    assign ev[`CTAC_ST_TIMEOUT_COUNT_LIMIT] = state_ff == CTAC_JUDGE && timed_out;
    assign ev[`CTAC_ST_DONE] = state_ff == CTAC_JUDGE && nxt_chan <= chan_ff;

    // Next flags: a read of status clears them, but an event in the same cycle is kept
    assign rd_clr = rd_en && adr_i == `CTAC_OFS_STATUS;
    assign nxt_status = rd_clr ? ev : (status_ff | ev);

    // Scan sequencer: gap, recharge cycles until crossing, judge, round wait
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_ff <= CTAC_IDLE;
            count_ff <= '0;
            chan_ff <= CHW'(NCH - 1);
            wait_ff <= 20'h00000;
            now_ff <= 1'b0;
        end else if (mode_ff == CTAC_MODE_OFF || xsel_ff == '0) begin
            // Park on the top channel so that the next round starts at the lowest enabled one
            state_ff <= CTAC_IDLE;
            chan_ff <= CHW'(NCH - 1);
            now_ff <= 1'b0;
        end else begin
            unique case (state_ff)
                CTAC_IDLE: begin
                    if (mode_ff == CTAC_MODE_CONT || !now_ff) begin
                        now_ff <= 1'b1;
                        chan_ff <= nxt_chan;
                        wait_ff <= 20'(rdelay_ff);
                        state_ff <= CTAC_GAP;
                    end
                end
                CTAC_GAP: if (tick_ff) begin
                    if (wait_ff == 20'h00000) begin
                        count_ff <= '0;
                        state_ff <= CTAC_DRIVE;
                    end else begin
                        wait_ff <= wait_ff - 20'h00001;
                    end
                end
                CTAC_DRIVE: if (tick_ff) begin
                    state_ff <= CTAC_SENSE;
                end
                CTAC_SENSE: if (tick_ff) begin
                    // Stop on crossing or count at the timeout limit; the count is the sensing value
                    if (cross_sync_ff[1] || count_ff >= timeout_count_limit_ff) begin
                        state_ff <= CTAC_JUDGE;
                    end else begin
                        count_ff <= count_ff + CW'(1);
                        state_ff <= CTAC_DRIVE;
                    end
                end
                CTAC_JUDGE: begin
                    chan_ff <= nxt_chan;
                    if (ev[`CTAC_ST_DONE]) begin
                        wait_ff <= 20'(round_ff) * 20'(`CTAC_ROUND_TICKS);
                        state_ff <= CTAC_WAIT;
                    end else begin
                        wait_ff <= 20'(rdelay_ff);
                        state_ff <= CTAC_GAP;
                    end
                end
                CTAC_WAIT: begin
                    // Continuous rounds repeat without software; one-shot stops
                    if (mode_ff != CTAC_MODE_CONT) begin
                        state_ff <= CTAC_IDLE;
                        chan_ff <= CHW'(NCH - 1);
                    end else if (tick_ff) begin
                        if (wait_ff == 20'h00000) begin
                            wait_ff <= 20'(rdelay_ff);
                            state_ff <= CTAC_GAP;
                        end else begin
                            wait_ff <= wait_ff - 20'h00001;
                        end
                    end
                end
                default: state_ff <= CTAC_IDLE;
            endcase
        end
    end

    // Result capture on each judge; touched index only updated on touch
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sense_ff <= '0;
            touched_channel_index_ff <= '0;
        end else if (state_ff == CTAC_JUDGE) begin
            sense_ff <= count_ff;
            if (is_touch) begin
                touched_channel_index_ff <= chan_ff;
            end
        end
    end

    // Sticky flags; a read of status clears but a same-cycle event wins
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            status_ff <= 4'h0;
        end else begin
            status_ff <= nxt_status;
        end
    end

    // Interrupt and wake are registered from the next flags; wake runs in any power state
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_o <= 1'b0;
            wake_o <= 1'b0;
        end else begin
            irq_o <= |(nxt_status & mask_ff);
            wake_o <= nxt_status[`CTAC_ST_YES] & mask_ff[`CTAC_ST_YES];
        end
    end

    // Pad drive, one flop pair per X pin; idle pins float unless the ground option holds them,
    // which keeps a floating neighbour from coupling into the pad being measured
    for (genvar g = 0; g < NCH; g++) begin : g_pad
        logic sel_here;
        assign sel_here = chan_ff == CHW'(g);
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                x_drive_o[g] <= 1'b0;
                x_oe_o[g] <= 1'b0;
            end else begin
                x_drive_o[g] <= sel_here && state_ff == CTAC_DRIVE;
                x_oe_o[g] <= (sel_here && (state_ff == CTAC_DRIVE || state_ff == CTAC_SENSE))
                    || xgnd_ff;
            end
        end
    end

    // Wishbone answer: one-cycle ack, unmapped reads return zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h00000000;
        end else begin
            ack_o <= cyc_i & stb_i & ~ack_o;
            dat_o <= 32'h00000000;
            if (rd_en) begin
                unique case (adr_i)
                    `CTAC_OFS_CTRL: dat_o <= 32'({16'(xsel_ff), 4'h0, fdiv_ff, 4'h0, xgnd_ff,
                        lower_ff, mode_ff});
                    `CTAC_OFS_THRESH: dat_o <= 32'({4'h0, timeout_count_limit_ff, 4'h0, thresh_ff});
                    `CTAC_OFS_TIMING: dat_o <= 32'({rdelay_ff, round_ff});
                    `CTAC_OFS_STATUS: dat_o <= 32'(status_ff);
                    `CTAC_OFS_MASK: dat_o <= 32'(mask_ff);
                    `CTAC_OFS_RESULT: dat_o <= 32'({12'(touched_channel_index_ff), 4'h0, sense_ff});
                    default: dat_o <= 32'h00000000;
                endcase
            end
        end
    end

    // Touch and no-touch never fire together at a judge
    one_event_a: assert property (@(posedge clk_i) disable iff (rst_i)
        state_ff == CTAC_JUDGE |-> ev[`CTAC_ST_YES] != ev[`CTAC_ST_NO])
        else $error("touch and no-touch not exclusive");
    // Touch flag set next cycle after a touch judge
    flag_sticks_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ev[`CTAC_ST_YES] |=> status_ff[`CTAC_ST_YES])
        else $error("touch flag not set");
    // Index captured on touch
    index_capt_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ev[`CTAC_ST_YES] |=> touched_channel_index_ff == $past(chan_ff))
        else $error("touched index not captured");
    // Higher count is touch when lower-is-touch is clear
    compare_dir_a: assert property (@(posedge clk_i) disable iff (rst_i)
        state_ff == CTAC_JUDGE && !lower_ff && count_ff > thresh_ff |-> ev[`CTAC_ST_YES])
        else $error("compare direction wrong");
    // Timeout event when count reaches limit
    timeout_ev_a: assert property (@(posedge clk_i) disable iff (rst_i)
        state_ff == CTAC_JUDGE && count_ff >= timeout_count_limit_ff |-> ev[`CTAC_ST_TIMEOUT_COUNT_LIMIT])
        else $error("timeout missing");
    // Sense value stored at judge
    sense_store_a: assert property (@(posedge clk_i) disable iff (rst_i)
        state_ff == CTAC_JUDGE |=> sense_ff == $past(count_ff))
        else $error("sense value not stored");
    // Wake follows unmasked touch flag on the next cycle
    wake_req_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ev[`CTAC_ST_YES] && mask_ff[`CTAC_ST_YES] |-> ##1 wake_o)
        else $error("wake not raised");
    // Round wait loads interval times 4096
    round_gap_a: assert property (@(posedge clk_i) disable iff (rst_i)
        state_ff == CTAC_JUDGE && ev[`CTAC_ST_DONE] |=>
        wait_ff == 20'($past(round_ff)) * 20'(`CTAC_ROUND_TICKS))
        else $error("round interval wrong");
    // A status read clears the touch flag unless a touch lands in the same cycle
    read_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
        rd_clr && !ev[`CTAC_ST_YES] |=> !status_ff[`CTAC_ST_YES])
        else $error("touch flag not cleared by read");
    // No pad is pulsed while waiting between rounds
    round_idle_a: assert property (@(posedge clk_i) disable iff (rst_i)
        state_ff == CTAC_WAIT |-> x_drive_o == '0)
        else $error("pad pulsed between rounds");
endmodule : ctac_scanner

// File: ctac_pad_model.sv
// Behavioural touch pad array: counts recharge pulses and trips the comparator
`timescale 1ns/1ps

module ctac_pad_model #(
    parameter int NCH = 16,
    parameter int IDLE_CNT = 5,
    parameter int TOUCH_CNT = 20
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Pad drive from the scanner
    input wire logic [NCH-1:0] x_drive_i,
    input wire logic [NCH-1:0] x_oe_i,
    // Which pads carry a finger
    input wire logic [NCH-1:0] touched_i,
    // Comparator level back to the scanner
    output logic y_cross_o
);
    logic [15:0] cnt_ff;
    logic last_ff;
    logic [NCH-1:0] act_ff;
    logic pulse;

    assign pulse = |(x_drive_i & x_oe_i);

    // Recharge pulses charge the pad; releasing every X pin between measurements discharges it,
    // so a stale crossing never carries into the next channel
    always_ff @(posedge clk_i) begin
        if (rst_i || x_oe_i == '0) begin
            cnt_ff <= 16'h0000;
            act_ff <= '0;
        end else if (x_oe_i != '0 && x_oe_i != act_ff) begin
            cnt_ff <= 16'h0000;
            act_ff <= x_oe_i;
        end else if (pulse && !last_ff) begin
            cnt_ff <= cnt_ff + 16'h0001;
        end
        last_ff <= pulse;
    end

    // Comparator reads low whenever no pad holds charge, so no stale level lingers
    assign y_cross_o = (act_ff != '0) && (cnt_ff >= ((|(touched_i & act_ff)) ? TOUCH_CNT : IDLE_CNT));
endmodule : ctac_pad_model

// File: tb_top.sv
// Self-checking bench of the touch scanner with a pad array model
`timescale 1ns/1ps
`include "ctac_defs.svh"

module tb_top;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc_i = 1'b0;
    logic stb_i = 1'b0;
    logic we_i = 1'b0;
    logic [7:0] adr_i = 8'h00;
    logic [3:0] sel_i = 4'hF;
    logic [31:0] dat_i = 32'h0000_0000;
    logic [31:0] dat_o;
    logic ack_o;
    logic [15:0] x_drive_o;
    logic [15:0] x_oe_o;
    logic y_cross_i;
    logic irq_o;
    logic wake_o;
    logic [15:0] touched = 16'h0000;
    int err_total = 0;
    int comparisons = 0;
    logic [31:0] q;

    // Clock at 250 MHz
    initial begin
        forever #2 clk_i = ~clk_i;
    end

    ctac_scanner ctac_scanner_inst (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .x_drive_o(x_drive_o), .x_oe_o(x_oe_o), .y_cross_i(y_cross_i), .irq_o(irq_o),
        .wake_o(wake_o));

    ctac_pad_model ctac_pad_model_inst (.clk_i(clk_i), .rst_i(rst_i), .x_drive_i(x_drive_o),
        .x_oe_i(x_oe_o), .touched_i(touched), .y_cross_o(y_cross_i));

    task automatic finish_test;
        if (err_total == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : finish_test

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic hang;
        err_total++;
        finish_test();
    endtask : hang

    // One classic cycle; request held until ack is sampled high
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rq);
        int n;
        logic got;
        n = 0;
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        do begin
            @(posedge clk_i);
            n++;
            got = ack_o;
        end while (got !== 1'b1 && n < 50);
        rq = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
        @(posedge clk_i);
        if (got !== 1'b1) hang();
    endtask : wb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] dummy;
        wb(1'b1, a, d, dummy);
    endtask : wr

    // Reset values and the unmapped hole
    task automatic t_reset;
        wb(1'b0, `CTAC_OFS_THRESH, 32'h0, q);
        chk(q, 32'h0FFF_0000);
        wr(8'h18, 32'hFFFF_FFFF);
        wb(1'b0, 8'h18, 32'h0, q);
        chk(q, 32'h0000_0000);
        chk({31'h0, irq_o}, 32'h0);
        chk({16'h0, x_oe_o}, 32'h0);
        // Ground option with the scan off: every X pin is held, none is pulsed
        wr(`CTAC_OFS_CTRL, 32'h0000_0008);
        repeat (2) @(posedge clk_i);
        chk({16'h0, x_oe_o}, 32'h0000_FFFF);
        chk({16'h0, x_drive_o}, 32'h0);
        wr(`CTAC_OFS_CTRL, 32'h0);
    endtask : t_reset

    // Single round: gather status bits until round done, then compare
    task automatic one_round(input logic [31:0] ctrl, input logic [3:0] exp);
        logic [31:0] acc;
        int n;
        acc = 32'h0;
        n = 0;
        wr(`CTAC_OFS_CTRL, 32'h0);
        wr(`CTAC_OFS_CTRL, ctrl);
        while (acc[2] !== 1'b1 && n < 400) begin
            wb(1'b0, `CTAC_OFS_STATUS, 32'h0, q);
            acc = acc | q;
            n++;
        end
        if (acc[2] !== 1'b1) hang();
        wb(1'b0, `CTAC_OFS_STATUS, 32'h0, q);
        acc = acc | q;
        chk({28'h0, acc[3:0]}, {28'h0, exp});
    endtask : one_round

    // Polarity, shared threshold and timeout in single rounds
    task automatic t_once;
        touched <= 16'h0002;
        wr(`CTAC_OFS_TIMING, 32'h0000_0101);
        wr(`CTAC_OFS_THRESH, 32'h0FFF_000A);
        one_round(32'h0001_0001, 4'h6);
        one_round(32'h0001_0005, 4'h5);
        one_round(32'h0002_0001, 4'h5);
        wr(`CTAC_OFS_THRESH, 32'h0008_0003);
        one_round(32'h0002_0001, 4'hD);
        wr(`CTAC_OFS_THRESH, 32'h0FFF_000A);
    endtask : t_once

    // Continuous scan with only the touch interrupt, as a sleeping system would run it
    task automatic t_cont;
        int n;
        int hi;
        time t0;
        wr(`CTAC_OFS_CTRL, 32'h0);
        wr(`CTAC_OFS_TIMING, 32'h0000_0101);
        wr(`CTAC_OFS_THRESH, 32'h0FFF_000A);
        wr(`CTAC_OFS_MASK, 32'h1);
        wb(1'b0, `CTAC_OFS_STATUS, 32'h0, q);
        // Divider zero keeps the tick undivided
        wr(`CTAC_OFS_CTRL, 32'h0003_0002);
        n = 0;
        while (irq_o !== 1'b1 && n < 20000) begin
            @(posedge clk_i);
            n++;
        end
        if (irq_o !== 1'b1) hang();
        t0 = $time;
        repeat (8) @(posedge clk_i);
        chk({31'h0, irq_o}, 32'h1);
        chk({31'h0, wake_o}, 32'h1);
        wb(1'b0, `CTAC_OFS_STATUS, 32'h0, q);
        chk({31'h0, q[0]}, 32'h1);
        wb(1'b0, `CTAC_OFS_RESULT, 32'h0, q);
        chk({20'h0, q[27:16]}, 32'h1);
        hi = 0;
        repeat (3000) begin
            @(posedge clk_i);
            hi = hi + ((irq_o === 1'b1) ? 1 : 0);
        end
        chk(hi, 0);
        n = 0;
        while (irq_o !== 1'b1 && n < 8000) begin
            @(posedge clk_i);
            n++;
        end
        chk({31'h0, irq_o}, 32'h1);
        // Next touch comes one round interval of 4096 ticks plus one round of measuring later
        chk({31'h0, ($time - t0) >= 64'd16384 && ($time - t0) < 64'd17600}, 32'h1);
        wr(`CTAC_OFS_CTRL, 32'h0);
        wb(1'b0, `CTAC_OFS_STATUS, 32'h0, q);
        repeat (2) @(posedge clk_i);
        chk({31'h0, irq_o}, 32'h0);
    endtask : t_cont

    // Main sequence
    initial begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        t_reset();
        t_once();
        t_cont();
        finish_test();
    end
endmodule : tb_top
